// [core/tcit_timer.sv]
// Functional notes
// - three fixed-role counters, count period 838 ns from 14.31818 MHz source
// - written initial count enters the counter one counter period later
// - counter 0 square wave: starts high, steps by two, toggles at zero
// - counter 1 rate mode: request drops one period when count reaches 1
// - counter 2 tone frequency is count rate divided by initial count rounded up to even
// - command bits 5:4 choose low, high or low-then-high count bytes
// - new count never changes programmed mode; effect depends on mode
// - one command port at 43h: program, latch and read-back commands
// - latch captures count while counting continues
// - read-back gives count, mode, output level and pending-load flag
// - six counting modes 0 to 5 chosen per counter
// - mode 0 output low, high at zero until reprogrammed
// - mode 1 output low, high one period at zero
// - mode 2 output high, low one period, then reload
// - mode 3 output starts high, toggles and reloads at each rollover
// - modes 4 and 5 output high, low one period on expiry
// - counters read and written at 40h, 41h, 42h in their format
// - latched count held until read or reprogram; second latch ignored
// - status read first, then latched count bytes, then live count
`timescale 1ns/1ps
module tcit_timer (
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire tcit_pkg::tcit_io_req_t io_req,
	output logic [7:0]                 io_rdata,
	input  wire logic                  tone_gate,
	input  wire logic                  speaker_enable,
	output logic                       system_tick_interrupt,
	output logic                       refresh_request,
	output logic                       speaker_tone,
	output logic [2:0]                 counter_out
);
	import tcit_pkg::*;

	localparam int TICK_GAP = CNT_TICK_CYC;

	function automatic logic [15:0] tcit_dec(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		logic        brw;
		r = v;
		brw = 1'b1;
		if (!bcd) begin
			r = v - 16'h0001;
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (brw) begin
					if (r[k*4 +: 4] == 4'h0) begin
						r[k*4 +: 4] = 4'h9;
					end else begin
						r[k*4 +: 4] = r[k*4 +: 4] - 4'h1;
						brw = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	function automatic tcit_mode_t tcit_norm_mode(input logic [2:0] m);
		return m[1] ? tcit_mode_t'({1'b0, m[1:0]}) : tcit_mode_t'(m);
	endfunction

	function automatic logic tcit_idle_out(input tcit_mode_t m);
		return !(m == M_EOC || m == M_ONESHOT);
	endfunction

	logic [TICK_W-1:0] tdiv_q;
	logic              tick;
	logic [7:0]        wd;
	logic [7:0]        rdata_q;
	logic              spk_q;
	logic [7:0]        rd_byte;
	logic [2:0]        sel_wr;
	logic [2:0]        sel_rd;
	logic [2:0]        cmd_prog;
	logic [2:0]        cmd_latch;
	logic [2:0]        cmd_status;
	logic [2:0]        gate;

	tcit_mode_t   mode_q [NUM_CNT];
	tcit_rw_t     rw_q   [NUM_CNT];
	tcit_status_t sts_q  [NUM_CNT];
	logic [15:0]  init_q [NUM_CNT];
	logic [15:0]  cnt_q  [NUM_CNT];
	logic [15:0]  lat_q  [NUM_CNT];
	logic [2:0]   bcd_q;
	logic [2:0]   out_q;
	logic [2:0]   null_q;
	logic [2:0]   ldp_q;
	logic [2:0]   run_q;
	logic [2:0]   wmsb_q;
	logic [2:0]   rmsb_q;
	logic [2:0]   latv_q;
	logic [2:0]   stsv_q;
	logic [2:0]   trig_q;
	logic [2:0]   gprev_q;

	assign wd = io_req.wdata;
	// count period tick
	assign tick = (tdiv_q == TICK_LAST);
	// gates of counters 0 and 1 held active
	assign gate = {tone_gate, 2'b11};

	always_ff @(posedge clock) begin
		if (srst || tick) begin
			tdiv_q <= '0;
		end else begin
			tdiv_q <= tdiv_q + TICK_W'(1);
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CNT; i++) begin
			sel_wr[i] = io_req.wr && io_req.addr == CNT0_PORT + 8'(i);
			sel_rd[i] = io_req.rd && io_req.addr == CNT0_PORT + 8'(i);
			cmd_prog[i] = io_req.wr && io_req.addr == CMD_PORT
				&& wd[CW_SC_LO +: 2] == 2'(i) && wd[CW_RW_LO +: 2] != RW_LATCH;
			cmd_latch[i] = io_req.wr && io_req.addr == CMD_PORT
				&& ((wd[CW_SC_LO +: 2] == 2'(i) && wd[CW_RW_LO +: 2] == RW_LATCH)
				|| (wd[CW_SC_LO +: 2] == SC_READBACK && !wd[RB_CNT_N]
				&& wd[RB_SEL_LO + i]));
			cmd_status[i] = io_req.wr && io_req.addr == CMD_PORT
				&& wd[CW_SC_LO +: 2] == SC_READBACK && !wd[RB_STS_N]
				&& wd[RB_SEL_LO + i];
		end
	end

	// read data selection: status, then latch, then live count
	always_comb begin
		logic [15:0] v;
		v = 16'h0000;
		rd_byte = 8'h00;
		for (int i = 0; i < NUM_CNT; i++) begin
			if (sel_rd[i]) begin
				v = latv_q[i] ? lat_q[i] : cnt_q[i];
				if (stsv_q[i]) begin
					rd_byte = sts_q[i];
				end else begin
					case (rw_q[i])
						RW_MSB:  rd_byte = v[15:8];
						RW_BOTH: rd_byte = rmsb_q[i] ? v[15:8] : v[7:0];
						default: rd_byte = v[7:0];
					endcase
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_q <= 8'h00;
			spk_q <= 1'b0;
		end else begin
			if (io_req.rd) begin
				rdata_q <= rd_byte;
			end
			spk_q <= out_q[2] && speaker_enable;
		end
	end

	assign io_rdata = rdata_q;
	assign system_tick_interrupt = out_q[0];
	assign refresh_request = out_q[1];
	assign speaker_tone = spk_q;
	assign counter_out = out_q;

	// counter channels
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < NUM_CNT; i++) begin
				mode_q[i] <= MODE_RST;
				rw_q[i] <= RW_RST;
				sts_q[i] <= '0;
				init_q[i] <= CNT_RST;
				cnt_q[i] <= CNT_RST;
				lat_q[i] <= CNT_RST;
			end
			{bcd_q, out_q, null_q, ldp_q, run_q, wmsb_q} <= '0;
			{rmsb_q, latv_q, stsv_q, trig_q, gprev_q} <= '0;
		end else begin
			for (int i = 0; i < NUM_CNT; i++) begin
				gprev_q[i] <= gate[i];
				if (gate[i] && !gprev_q[i]) begin
					trig_q[i] <= 1'b1;
				end else if (tick) begin
					trig_q[i] <= 1'b0;
				end

				if (cmd_prog[i]) begin
					latv_q[i] <= 1'b0;
				end else if (cmd_latch[i] && !latv_q[i]) begin
					lat_q[i] <= cnt_q[i];
					latv_q[i] <= 1'b1;
				end else if (sel_rd[i] && !stsv_q[i] && latv_q[i]
						&& (rw_q[i] != RW_BOTH || rmsb_q[i])) begin
					latv_q[i] <= 1'b0;
				end

				if (cmd_prog[i]) begin
					rmsb_q[i] <= 1'b0;
				end else if (sel_rd[i] && !stsv_q[i] && rw_q[i] == RW_BOTH) begin
					rmsb_q[i] <= ~rmsb_q[i];
				end

				if (cmd_prog[i]) begin
					stsv_q[i] <= 1'b0;
				end else if (cmd_status[i] && !stsv_q[i]) begin
					sts_q[i] <= '{out_q[i], null_q[i], rw_q[i], mode_q[i], bcd_q[i]};
					stsv_q[i] <= 1'b1;
				end else if (sel_rd[i]) begin
					stsv_q[i] <= 1'b0;
				end

				if (cmd_prog[i]) begin
					mode_q[i] <= tcit_norm_mode(wd[CW_MODE_LO +: 3]);
					rw_q[i] <= tcit_rw_t'(wd[CW_RW_LO +: 2]);
					bcd_q[i] <= wd[CW_BCD];
					out_q[i] <= tcit_idle_out(tcit_norm_mode(wd[CW_MODE_LO +: 3]));
					null_q[i] <= 1'b1;
					ldp_q[i] <= 1'b0;
					run_q[i] <= 1'b0;
					wmsb_q[i] <= 1'b0;
				end else begin
					if (tick) begin
						case (mode_q[i])
							M_EOC: begin
								if (ldp_q[i]) begin
									cnt_q[i] <= init_q[i];
									{ldp_q[i], null_q[i], run_q[i]} <= 3'b001;
									out_q[i] <= 1'b0;
								end else if (run_q[i] && gate[i]) begin
									cnt_q[i] <= tcit_dec(cnt_q[i], bcd_q[i]);
									if (cnt_q[i] == 16'h0001) begin
										out_q[i] <= 1'b1;
									end
								end
							end
							M_SWSTB: begin
								out_q[i] <= 1'b1;
								if (ldp_q[i]) begin
									cnt_q[i] <= init_q[i];
									{ldp_q[i], null_q[i], run_q[i]} <= 3'b001;
								end else if (run_q[i] && gate[i]) begin
									cnt_q[i] <= tcit_dec(cnt_q[i], bcd_q[i]);
									if (cnt_q[i] == 16'h0001) begin
										out_q[i] <= 1'b0;
										run_q[i] <= 1'b0;
									end
								end
							end
							M_ONESHOT, M_HWSTB: begin
								out_q[i] <= tcit_idle_out(mode_q[i]);
								if (trig_q[i] && (ldp_q[i] || !null_q[i])) begin
									cnt_q[i] <= init_q[i];
									{ldp_q[i], null_q[i], run_q[i]} <= 3'b001;
								end else if (run_q[i]) begin
									cnt_q[i] <= tcit_dec(cnt_q[i], bcd_q[i]);
									if (cnt_q[i] == 16'h0001) begin
										out_q[i] <= !tcit_idle_out(mode_q[i]);
										run_q[i] <= 1'b0;
									end
								end
							end
							M_RATE: begin
								if (!gate[i]) begin
									out_q[i] <= 1'b1;
								end else if (ldp_q[i] && !run_q[i]) begin
									cnt_q[i] <= init_q[i];
									{ldp_q[i], null_q[i], run_q[i]} <= 3'b001;
									out_q[i] <= 1'b1;
								end else if (run_q[i]) begin
									if (cnt_q[i] == 16'h0001) begin
										cnt_q[i] <= init_q[i];
										{ldp_q[i], null_q[i]} <= 2'b00;
										out_q[i] <= 1'b1;
									end else begin
										cnt_q[i] <= tcit_dec(cnt_q[i], bcd_q[i]);
										out_q[i] <= cnt_q[i] != 16'h0002;
									end
								end
							end
							M_SQUARE: begin
								if (!gate[i]) begin
									out_q[i] <= 1'b1;
								end else if (ldp_q[i] && !run_q[i]) begin
									cnt_q[i] <= init_q[i];
									{ldp_q[i], null_q[i], run_q[i]} <= 3'b001;
									out_q[i] <= 1'b1;
								end else if (run_q[i]) begin
									if (cnt_q[i] == 16'h0001 || cnt_q[i] == 16'h0002) begin
										cnt_q[i] <= init_q[i];
										{ldp_q[i], null_q[i]} <= 2'b00;
										out_q[i] <= ~out_q[i];
									end else begin
										cnt_q[i] <= tcit_dec(tcit_dec(cnt_q[i], bcd_q[i]),
											bcd_q[i]);
									end
								end
							end
							default: begin
								out_q[i] <= out_q[i];
							end
						endcase
					end
					// count write overrides a same-cycle load so it is not lost
					if (sel_wr[i]) begin
						if (rw_q[i] == RW_BOTH && !wmsb_q[i]) begin
							init_q[i][7:0] <= wd;
							wmsb_q[i] <= 1'b1;
							if (mode_q[i] == M_EOC) begin
								run_q[i] <= 1'b0;
							end
						end else begin
							case (rw_q[i])
								RW_MSB:  init_q[i] <= {wd, 8'h00};
								RW_BOTH: init_q[i][15:8] <= wd;
								default: init_q[i] <= {8'h00, wd};
							endcase
							wmsb_q[i] <= 1'b0;
							ldp_q[i] <= 1'b1;
							null_q[i] <= 1'b1;
							if (mode_q[i] == M_EOC) begin
								run_q[i] <= 1'b0;
								out_q[i] <= 1'b0;
							end
						end
					end
				end
			end
		end
	end

	chk_tick_gap: assert property (@(posedge clock) disable iff (srst)
		tick |-> ##TICK_GAP tick) else $error("count period tick spacing wrong");
	chk_prog_mode: assert property (@(posedge clock) disable iff (srst)
		cmd_prog[0] |=> mode_q[0] == tcit_norm_mode($past(wd[3:1])) && null_q[0])
		else $error("program command did not set mode");
	chk_null_clear: assert property (@(posedge clock) disable iff (srst)
		(tick && ldp_q[1] && mode_q[1] == M_EOC && !cmd_prog[1] && !sel_wr[1])
		|=> !null_q[1] && cnt_q[1] == $past(init_q[1]))
		else $error("pending count not loaded at tick");
	chk_eoc_hold: assert property (@(posedge clock) disable iff (srst)
		(mode_q[1] == M_EOC && out_q[1] && !cmd_prog[1] && !sel_wr[1]) |=> out_q[1])
		else $error("mode 0 output fell without reprogramming");
	chk_rate_pulse: assert property (@(posedge clock) disable iff (srst)
		(mode_q[1] == M_RATE && $fell(out_q[1]) && !cmd_prog[1])
		|-> ##TICK_GAP out_q[1]) else $error("refresh low pulse not one period");
	chk_sq_toggle: assert property (@(posedge clock) disable iff (srst)
		(mode_q[0] == M_SQUARE && $changed(out_q[0]) && !$past(cmd_prog[0]))
		|-> $past(tick)) else $error("square output changed off tick");
	chk_latch_take: assert property (@(posedge clock) disable iff (srst)
		(cmd_latch[0] && !latv_q[0]) |=> latv_q[0] && lat_q[0] == $past(cnt_q[0]))
		else $error("latch did not capture count");
	chk_latch_hold: assert property (@(posedge clock) disable iff (srst)
		(latv_q[0] && !cmd_prog[0] && !sel_rd[0]) |=> latv_q[0] && $stable(lat_q[0]))
		else $error("latched count changed before read");
	chk_status_first: assert property (@(posedge clock) disable iff (srst)
		(sel_rd[0] && stsv_q[0]) |=> io_rdata == $past(sts_q[0]) && !stsv_q[0])
		else $error("status not returned first");
endmodule

// [core/tcit_pkg.sv]
package tcit_pkg;
	// i/o ports of the timer
	localparam logic [7:0] CNT0_PORT = 8'h40;
	localparam logic [7:0] CMD_PORT  = 8'h43;
	localparam int         NUM_CNT   = 3;

	// timing: one counter period is 838 ns, clock is 25 ns
	localparam int INPUT_CLK_HZ  = 14318180;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CNT_PERIOD_NS = 838;
	localparam int CNT_TICK_CYC  = CNT_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK_W        = 6;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CNT_TICK_CYC - 1);

	// command word fields
	localparam int CW_SC_LO   = 6;
	localparam int CW_RW_LO   = 4;
	localparam int CW_MODE_LO = 1;
	localparam int CW_BCD     = 0;
	localparam int RB_CNT_N   = 5;
	localparam int RB_STS_N   = 4;
	localparam int RB_SEL_LO  = 1;
	localparam logic [1:0] SC_READBACK = 2'h3;

	typedef enum logic [1:0] {
		RW_LATCH = 2'b00,
		RW_LSB   = 2'b01,
		RW_MSB   = 2'b10,
		RW_BOTH  = 2'b11
	} tcit_rw_t;

	typedef enum logic [2:0] {
		M_EOC     = 3'b000,
		M_ONESHOT = 3'b001,
		M_RATE    = 3'b010,
		M_SQUARE  = 3'b011,
		M_SWSTB   = 3'b100,
		M_HWSTB   = 3'b101
	} tcit_mode_t;

	// reset values
	localparam tcit_mode_t  MODE_RST = M_EOC;
	localparam tcit_rw_t    RW_RST   = RW_LSB;
	localparam logic [15:0] CNT_RST  = 16'h0000;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tcit_io_req_t;

	typedef struct packed {
		logic       out;
		logic       null_cnt;
		tcit_rw_t   rw;
		tcit_mode_t mode;
		logic       bcd;
	} tcit_status_t;
endpackage

// [tb/tcit_host.sv]
`timescale 1ns/1ps
module tcit_host (
	input  wire logic              clock,
	output tcit_pkg::tcit_io_req_t io_req,
	input  wire logic [7:0]        io_rdata
);
	import tcit_pkg::*;
	initial io_req = '0;
	// one-cycle write pulse, driven between rising edges
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clock);
		io_req = '0;
	endtask
	// read data is taken two cycles after the request is driven
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clock);
		io_req = '0;
		@(negedge clock);
		d = io_rdata;
	endtask
endmodule

// [tb/tcit_timer_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module tcit_timer_tb;
	import tcit_pkg::*;
	localparam int T = CNT_TICK_CYC;
	logic         clock = 1'b0;
	logic         srst = 1'b1;
	tcit_io_req_t io_req;
	logic [7:0]   io_rdata;
	logic         tone_gate = 1'b1;
	logic         speaker_enable = 1'b0;
	logic         system_tick_interrupt;
	logic         refresh_request;
	logic         speaker_tone;
	logic [2:0]   counter_out;
	logic         tone_d = 1'b0;
	logic [7:0]   b;
	int           err_count = 0;
	int           n_tests = 0;
	int           n, c, v1, v2;

	always #12.5 clock = ~clock;

	tcit_timer i_tcit_timer (
		.clock                 (clock),
		.srst                  (srst),
		.io_req                (io_req),
		.io_rdata              (io_rdata),
		.tone_gate             (tone_gate),
		.speaker_enable        (speaker_enable),
		.system_tick_interrupt (system_tick_interrupt),
		.refresh_request       (refresh_request),
		.speaker_tone          (speaker_tone),
		.counter_out           (counter_out)
	);

	tcit_host i_tcit_host (
		.clock    (clock),
		.io_req   (io_req),
		.io_rdata (io_rdata)
	);

	always @(posedge clock) begin
		tone_d <= counter_out[2] & speaker_enable;
	end

	always @(negedge clock) begin
		if (!srst) begin
			`CHK({system_tick_interrupt, refresh_request}, {counter_out[0], counter_out[1]})
			`CHK(speaker_tone, tone_d)
		end
	end

	task automatic w(input logic [7:0] a, input logic [7:0] d);
		i_tcit_host.wr(a, d);
	endtask

	task automatic r(input int k);
		i_tcit_host.rd(CNT0_PORT + 8'(k), b);
	endtask

	task automatic rd16(input int k, output int v);
		r(k);
		v = b;
		r(k);
		v = v | (int'(b) << 8);
	endtask

	// command word first, then low and high count bytes
	task automatic prog(input int k, input int m, input int cnt);
		w(CMD_PORT, {k[1:0], 2'h3, m[2:0], 1'b0});
		w(CNT0_PORT + 8'(k), 8'(cnt));
		w(CNT0_PORT + 8'(k), 8'(cnt >> 8));
	endtask

	// cycles until counter output k shows level lvl
	task automatic wl(input int k, input logic lvl);
		c = 0;
		while (counter_out[k] !== lvl && c < 5000) begin
			@(negedge clock);
			c++;
		end
	endtask

	function automatic logic [7:0] sts(input int m, input logic o, input logic p);
		return {o, p, 2'h3, m[2:0], 1'b0};
	endfunction

	task automatic end_of_test;
		if (err_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#(25 * 40000);
		err_count++;
		end_of_test;
	end

	initial begin
		n = $urandom(34090);
		repeat (8) @(negedge clock);
		srst = 1'b0;
		`CHK({counter_out, io_rdata}, 11'h000)
		i_tcit_host.rd(CMD_PORT, b);
		`CHK(b, 8'h00)
		i_tcit_host.rd(8'h44, b);
		`CHK(b, 8'h00)
		for (int m = 0; m < 6; m++) begin
			w(CMD_PORT, {2'h2, 2'h3, 3'(m), 1'b0});
			w(CMD_PORT, 8'he8);
			w(CMD_PORT, 8'he8);
			r(2);
			`CHK(b, sts(m, m > 1, 1'b1))
		end
		n = 4 + $urandom % 5;
		prog(1, 2, n);
		repeat (70) @(negedge clock);
		w(CMD_PORT, 8'he4);
		r(1);
		`CHK(b, sts(2, 1'b1, 1'b0))
		wl(1, 0);
		wl(1, 1);
		`CHK(c, T)
		wl(1, 0);
		`CHK(c, (n - 1) * T)
		w(8'h41, 8'(n + 2));
		w(8'h41, 8'h00);
		w(CMD_PORT, 8'he4);
		r(1);
		`CHK(b[6:0], 7'h74)
		n = 2 * (2 + $urandom % 9);
		prog(0, 3, n);
		`CHK(counter_out[0], 1'b1)
		wl(0, 0);
		wl(0, 1);
		`CHK(c, n / 2 * T)
		wl(0, 0);
		`CHK(c, n / 2 * T)
		prog(0, 2, 16'h1000);
		repeat (70) @(negedge clock);
		w(CMD_PORT, 8'h00);
		repeat (330) @(negedge clock);
		w(CMD_PORT, 8'h00);
		rd16(0, v1);
		w(CMD_PORT, 8'h00);
		rd16(0, v2);
		`CHK((v1 - v2) inside {[10:12]}, 1'b1)
		w(CMD_PORT, 8'hc2);
		r(0);
		`CHK(b, sts(2, 1'b1, 1'b0))
		rd16(0, v1);
		`CHK((v2 - v1) inside {[0:2]}, 1'b1)
		// reprogram only while the refresh request is high
		wl(1, 1);
		n = 3 + $urandom % 6;
		prog(1, 0, n);
		wl(1, 1);
		`CHK(c >= n * T - 2 && c <= (n + 2) * T, 1'b1)
		repeat (2 * n * T) @(negedge clock);
		`CHK(counter_out[1], 1'b1)
		prog(1, 4, n);
		wl(1, 0);
		wl(1, 1);
		`CHK(c, T)
		// bcd count, low byte only, crossing the tens digit
		n = 10 + $urandom % 10;
		w(CMD_PORT, 8'h55);
		w(8'h41, {4'h1, 4'(n - 10)});
		wl(1, 0);
		wl(1, 1);
		`CHK(c, T)
		wl(1, 0);
		`CHK(c, (n - 1) * T)
		// mode 6 aliases mode 2, high byte only
		w(CMD_PORT, 8'h6c);
		w(CMD_PORT, 8'he4);
		r(1);
		`CHK(b, 8'he4)
		w(8'h41, 8'h02);
		repeat (40) @(negedge clock);
		w(CMD_PORT, 8'h40);
		r(1);
		`CHK(b inside {8'h01, 8'h02}, 1'b1)
		for (int m = 1; m < 6; m += 4) begin
			tone_gate = 1'b0;
			prog(2, m, n);
			tone_gate = 1'b1;
			wl(2, m == 1);
			wl(2, m != 1);
			`CHK(c, T)
		end
		speaker_enable = 1'b1;
		n = 2 * (2 + $urandom % 9);
		prog(2, 3, n);
		wl(2, 0);
		wl(2, 1);
		`CHK(c, n / 2 * T)
		tone_gate = 1'b0;
		repeat (2) @(negedge clock);
		`CHK(counter_out[2], 1'b1)
		end_of_test;
	end
endmodule
